// ---- hdl/smlp_map.vh ----
// Constants for the modem line and PWM pin sharing block.
// Assumes inclusion by bare name from the design files.
`ifndef SMLP_MAP_VH
`define SMLP_MAP_VH
// Modem status register field positions
`define SMLP_STAT_CTS_DELTA_BIT 0
`define SMLP_STAT_RI_TRAIL_BIT  2
`define SMLP_STAT_CTS_BIT       4
`define SMLP_STAT_RI_BIT        6
// Modem control register field positions
`define SMLP_CTRL_DTR_BIT       0
// Interrupt enable register field position
`define SMLP_IER_MODEM_BIT     3
// Peripheral config space register and pin select bit
`define SMLP_CFG_PINSEL_OFFSET 8'hC0
`define SMLP_CFG_PINSEL_BIT    2
// Reset values
`define SMLP_DTR_OUT_RESET     1'h1
`define SMLP_TX_IND_RESET      1'h0
`define SMLP_TX_OE_RESET       1'h1
`define SMLP_PWM_IN_RESET      1'h0
`define SMLP_IRQ_RESET         1'h0
`define SMLP_STATUS_RESET      8'h00
`define SMLP_SYNC_RESET        2'h3
`endif

// ---- hdl/smlp_sync.v ----
// Two-stage synchroniser with a constant reset value.
// Assumes clk_i is the only clock; resetn_i is synchronous, active low.
`timescale 1ns/1ps
module smlp_sync #(
  parameter RESET_VAL = 1'b1
) (
  input  wire clk_i,
  input  wire resetn_i,
  input  wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end
  assign q_o = sync_reg;
endmodule // smlp_sync

// ---- hdl/smlp_modem_lines.v ----
// Modem handshake lines of the second serial port and their PWM pin sharing.
// Assumes a UART core supplies register strobes and transmit activity; pins on clk_i.
`timescale 1ns/1ps
`include "smlp_map.vh"
module smlp_modem_lines (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       ring_indicator_low_i,
  input  wire       cts_low_i,
  input  wire       tx_activity_pin_i,
  input  wire       dtr_ctrl_i,
  input  wire       loopback_i,
  input  wire       modem_irq_en_i,
  input  wire       status_read_i,
  input  wire       pin_select_i,
  input  wire       tx_busy_i,
  input  wire       pwm_timer_out_i,
  output wire       terminal_ready_out_o,
  output wire       tx_activity_indicator_o,
  output wire       tx_activity_oe_o,
  output wire       pwm_timer1_ext_clock_o,
  output wire       pwm_timer2_gate_mask_o,
  output wire [7:0] modem_line_status_o,
  output wire       modem_irq_o
);
  // ==========================================================
  // Input synchronisers
  wire ri_sync;
  wire cts_sync;
  wire gate_sync;
  smlp_sync #(.RESET_VAL(1'b1)) u_ri_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (ring_indicator_low_i),
    .q_o      (ri_sync)
  );

  smlp_sync #(.RESET_VAL(1'b1)) u_cts_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (cts_low_i),
    .q_o      (cts_sync)
  );

  smlp_sync #(.RESET_VAL(1'b0)) u_gate_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (tx_activity_pin_i),
    .q_o      (gate_sync)
  );

  // ==========================================================
  // Ring edge detection and trailing flag
  reg  ri_prev_reg;
  reg  ri_trail_reg;
  reg  ri_trail_next;
  wire ri_rise   = ri_sync & ~ri_prev_reg;
  wire ri_change = ri_sync ^ ri_prev_reg;
  wire serial_mode = ~pin_select_i;

  always @* begin
    ri_trail_next = ri_trail_reg;
    if (status_read_i)
      ri_trail_next = 1'h0;
    if (ri_rise && serial_mode)
      ri_trail_next = 1'h1;
  end

  // Reset level matches the idle pin so no false edge follows reset
  always @(posedge clk_i) begin
    if (!resetn_i)
      ri_prev_reg <= 1'h1;
    else
      ri_prev_reg <= ri_sync;
  end

  always @(posedge clk_i) begin
    if (!resetn_i)
      ri_trail_reg <= 1'h0;
    else
      ri_trail_reg <= ri_trail_next;
  end

  // ==========================================================
  // Terminal-ready pin: PWM output wins over loopback and control bit
  // Loopback holds the pin inactive so the modem never sees a false ready
  reg  dtr_pin_reg;
  reg  dtr_pin_next;

  always @* begin
    dtr_pin_next = ~dtr_ctrl_i;
    if (pin_select_i)
      dtr_pin_next = pwm_timer_out_i;
    else if (loopback_i)
      dtr_pin_next = 1'h1;
  end

  always @(posedge clk_i) begin
    if (!resetn_i)
      dtr_pin_reg <= `SMLP_DTR_OUT_RESET;
    else
      dtr_pin_reg <= dtr_pin_next;
  end

  // ==========================================================
  // Transmit activity pin: driven only while it serves the serial port
  // With the pins given to PWM the pad turns round and feeds timer 2
  reg  tx_ind_reg;
  reg  tx_ind_next;
  reg  tx_oe_reg;
  reg  tx_oe_next;

  always @* begin
    tx_oe_next  = serial_mode;
    tx_ind_next = 1'h0;
    if (serial_mode)
      tx_ind_next = tx_busy_i;
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      tx_ind_reg <= `SMLP_TX_IND_RESET;
      tx_oe_reg  <= `SMLP_TX_OE_RESET;
    end else begin
      tx_ind_reg <= tx_ind_next;
      tx_oe_reg  <= tx_oe_next;
    end
  end

  // ==========================================================
  // PWM timer inputs: held low while the pins serve the serial port
  // Ring edges are not flagged while the ring pin clocks timer 1
  reg  pwm_clk_reg;
  reg  pwm_clk_next;
  reg  pwm_gate_reg;
  reg  pwm_gate_next;

  always @* begin
    pwm_clk_next  = 1'h0;
    pwm_gate_next = 1'h0;
    if (pin_select_i) begin
      pwm_clk_next  = ri_sync;
      pwm_gate_next = gate_sync;
    end
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pwm_clk_reg  <= `SMLP_PWM_IN_RESET;
      pwm_gate_reg <= `SMLP_PWM_IN_RESET;
    end else begin
      pwm_clk_reg  <= pwm_clk_next;
      pwm_gate_reg <= pwm_gate_next;
    end
  end

  // ==========================================================
  // Modem status byte; the trailing flag shows in the cycle it is set
  // Unused bits read as zero; the other handshake lines live elsewhere
  reg  [7:0] status_reg;
  reg  [7:0] status_next;

  always @* begin
    status_next                          = `SMLP_STATUS_RESET;
    status_next[`SMLP_STAT_RI_BIT]       = ~ri_sync;
    status_next[`SMLP_STAT_CTS_BIT]      = ~cts_sync;
    status_next[`SMLP_STAT_RI_TRAIL_BIT] = ri_trail_next;
  end

  always @(posedge clk_i) begin
    if (!resetn_i)
      status_reg <= `SMLP_STATUS_RESET;
    else
      status_reg <= status_next;
  end

  // ==========================================================
  // Modem status interrupt: a ring change in the same cycle beats a status-read clear
  // Cleared by a status read or by dropping the enable bit
  reg  irq_reg;
  reg  irq_next;

  always @* begin
    irq_next = irq_reg;
    if (status_read_i || !modem_irq_en_i)
      irq_next = 1'h0;
    if (ri_change && serial_mode && modem_irq_en_i)
      irq_next = 1'h1;
  end

  always @(posedge clk_i) begin
    if (!resetn_i)
      irq_reg <= `SMLP_IRQ_RESET;
    else
      irq_reg <= irq_next;
  end

  // ==========================================================
  // Output pins, each straight from its flip-flop
  // No output is combinational, so pad timing is set by the flip-flops
  assign terminal_ready_out_o    = dtr_pin_reg;
  assign tx_activity_indicator_o = tx_ind_reg;
  assign tx_activity_oe_o        = tx_oe_reg;
  assign pwm_timer1_ext_clock_o  = pwm_clk_reg;
  assign pwm_timer2_gate_mask_o  = pwm_gate_reg;
  assign modem_line_status_o     = status_reg;
  assign modem_irq_o             = irq_reg;
endmodule // smlp_modem_lines

// ---- testbench/smlp_props.sv ----
// Checker of the modem line block ports.
// Assumes binding into smlp_modem_lines.
`timescale 1ns/1ps
module smlp_props (
  input wire clk_i, resetn_i, ring_indicator_low_i, cts_low_i, tx_activity_pin_i,
  input wire dtr_ctrl_i, loopback_i, modem_irq_en_i, status_read_i, pin_select_i,
  input wire tx_busy_i, pwm_timer_out_i, terminal_ready_out_o, tx_activity_oe_o,
  input wire pwm_timer1_ext_clock_o, pwm_timer2_gate_mask_o, modem_irq_o,
  input wire tx_activity_indicator_o,
  input wire [7:0] modem_line_status_o
);
  reg  [2:0] up_cnt;
  wire       ri = ring_indicator_low_i;
  wire       sel = pin_select_i;
  wire       warm = up_cnt[2];
  wire [7:0] st = modem_line_status_o;
  // Warm once the pin synchronisers hold post-reset samples
  always @(posedge clk_i) begin
    up_cnt <= !resetn_i ? 3'h0 : up_cnt + {2'h0, !warm};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ri_stat_a: assert property (warm && !sel |-> st[6] == !$past(ri, 3)) else $error("ri");
  cts_stat_a: assert property (warm |-> st[4] == !$past(cts_low_i, 3)) else $error("cts");
  ri_flag_a: assert property ($rose(ri) && !sel |-> ##[1:4] st[2]) else $error("flag");
  ri_irq_a: assert property ($changed(ri) && !sel && modem_irq_en_i |-> ##[1:4] modem_irq_o)
    else $error("irq");
  rd_clr_a: assert property (status_read_i && $stable(ri) && $past(ri, 4) == ri |=> !st[2])
    else $error("read");
  dtr_a: assert property ($past(resetn_i && !sel && !loopback_i) |->
    terminal_ready_out_o == !$past(dtr_ctrl_i)) else $error("dtr");
  pwm_dtr_a: assert property ($past(resetn_i && sel) |->
    terminal_ready_out_o == $past(pwm_timer_out_i)) else $error("pwm out");
  pwm_on_a: assert property (warm && $past(sel) && $past(sel, 3) |->
    pwm_timer1_ext_clock_o == $past(ri, 3) && !tx_activity_oe_o &&
    pwm_timer2_gate_mask_o == $past(tx_activity_pin_i, 3)) else $error("pwm on");
  pwm_off_a: assert property (!$past(sel) && !$past(sel, 3) |->
    !pwm_timer1_ext_clock_o && !pwm_timer2_gate_mask_o) else $error("pwm off");
  tx_ind_a: assert property ($past(resetn_i) |->
    tx_activity_indicator_o == $past(!sel && tx_busy_i)) else $error("tx ind");
  lb_dtr_a: assert property ($past(resetn_i && !sel && loopback_i) |-> terminal_ready_out_o)
    else $error("loopback");
  cover property (modem_irq_o ##1 status_read_i);
  cover property (sel && pwm_timer1_ext_clock_o);
  cover property ($rose(st[2]));
endmodule // smlp_props
bind smlp_modem_lines smlp_props u_props (.*);

// ---- testbench/smlp_modem_model.sv ----
// Modem side: drives the active-low ring and clear-to-send pins.
// Assumes calls just after a rising clock edge; idle is high.
`timescale 1ns/1ps
module smlp_modem_model (
  output reg ring_low_o,
  output reg cts_low_o
);
  initial {ring_low_o, cts_low_o} = 2'h3;
  task drive(input r, input c);
    {ring_low_o, cts_low_o} = {r, c};
  endtask
endmodule // smlp_modem_model

// ---- testbench/testbench.sv ----
// Bench of the modem line block.
// Assumes design, checker and modem model compiled first.
`timescale 1ns/1ps
module testbench;
  reg clk_i, resetn_i, tx_activity_pin_i, dtr_ctrl_i, loopback_i, modem_irq_en_i;
  reg status_read_i, pin_select_i, tx_busy_i, pwm_timer_out_i;
  wire ring_indicator_low_i, cts_low_i, terminal_ready_out_o, tx_activity_indicator_o;
  wire tx_activity_oe_o, pwm_timer1_ext_clock_o, pwm_timer2_gate_mask_o, modem_irq_o;
  wire [7:0] modem_line_status_o;
  wire [7:0] pins = {2'h0, terminal_ready_out_o, tx_activity_indicator_o, tx_activity_oe_o,
    pwm_timer1_ext_clock_o, pwm_timer2_gate_mask_o, modem_irq_o};
  integer error_cnt = 0;
  integer samples_checked = 0;
  smlp_modem_lines dut (.*);
  smlp_modem_model modem (.ring_low_o(ring_indicator_low_i), .cts_low_o(cts_low_i));
  task cyc(input integer n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task rd;
    status_read_i = 1'b1;
    cyc(1);
    status_read_i = 1'b0;
    cyc(1);
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  initial begin
    {resetn_i, tx_activity_pin_i, dtr_ctrl_i, loopback_i, modem_irq_en_i} = 5'h00;
    {status_read_i, pin_select_i, tx_busy_i, pwm_timer_out_i} = 4'h0;
    cyc(4);
    resetn_i = 1'b1;
    cyc(4);
    chk("status", 8'h00, modem_line_status_o);
    chk("pins", 8'h28, pins);
    dtr_ctrl_i = 1'b1;
    cyc(2);
    chk("pins", 8'h08, pins);
    loopback_i = 1'b1;
    cyc(2);
    chk("pins", 8'h28, pins);
    $display("terminal ready test done");
    {loopback_i, modem_irq_en_i} = 2'h1;
    modem.drive(1'b0, 1'b0);
    cyc(5);
    chk("status", 8'h50, modem_line_status_o);
    chk("pins", 8'h09, pins);
    rd;
    chk("pins", 8'h08, pins);
    modem.drive(1'b1, 1'b0);
    cyc(5);
    chk("status", 8'h14, modem_line_status_o);
    rd;
    chk("status", 8'h10, modem_line_status_o);
    modem_irq_en_i = 1'b0;
    modem.drive(1'b0, 1'b0);
    cyc(5);
    chk("pins", 8'h08, pins);
    $display("ring test done");
    tx_busy_i = 1'b1;
    cyc(2);
    chk("pins", 8'h18, pins);
    {pin_select_i, pwm_timer_out_i, tx_activity_pin_i} = 3'h7;
    modem.drive(1'b1, 1'b0);
    cyc(5);
    chk("pins", 8'h26, pins);
    chk("status", 8'h10, modem_line_status_o);
    pin_select_i = 1'b0;
    cyc(5);
    chk("pins", 8'h18, pins);
    $display("pin share test done");
    resetn_i = 1'b0;
    cyc(2);
    chk("status", 8'h00, modem_line_status_o);
    chk("pins", 8'h28, pins);
    resetn_i = 1'b1;
    cyc(4);
    chk("status", 8'h10, modem_line_status_o);
    chk("pins", 8'h18, pins);
    $display("mid-run reset test done");
    stop_test;
  end
endmodule // testbench
